// ==== src/positioner_extended_diagnosis.sv ====
module positioner_extended_diagnosis #(
  parameter int unsigned VAL_W = diag_pkg::VAL_W,
  parameter int unsigned CNT_W = diag_pkg::CNT_W
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  // Direct system fault and process alarm conditions
  input wire logic option_board_fault_i,
  input wire logic pot_fault_i,
  input wire logic ip_loop_broken_i,
  input wire logic actuator_out_of_range_i,
  input wire logic converter_fault_i,
  input wire logic rom_checksum_fault_i,
  input wire logic eeprom_checksum_fault_i,
  input wire logic ram_test_fault_i,
  input wire logic binary_input_active_i,
  input wire logic feedback_cal_fault_i,
  input wire logic loop_cal_fault_i,
  input wire logic config_invalid_i,
  input wire logic output_pressure_implausible_i,
  input wire logic autostart_failed_i,
  // Counters and thresholds
  input wire logic [CNT_W-1:0] stroke_cycle_count_i,
  input wire logic [CNT_W-1:0] stroke_cycle_limit_i,
  input wire logic [CNT_W-1:0] travel_sum_i,
  input wire logic [CNT_W-1:0] travel_sum_limit_i,
  // Analog readings and thresholds, unsigned codes; deviation dwell in cycles
  input wire logic [VAL_W-1:0] board_temp_i,
  input wire logic [VAL_W-1:0] board_temp_low_threshold_i,
  input wire logic [VAL_W-1:0] board_temp_high_threshold_i,
  input wire logic [VAL_W-1:0] supply_pressure_reading_i,
  input wire logic [VAL_W-1:0] supply_pressure_min_i,
  input wire logic [VAL_W-1:0] control_deviation_i,
  input wire logic [VAL_W-1:0] deviation_threshold_i,
  input wire logic [CNT_W-1:0] deviation_dwell_cycles_i,
  input wire logic [VAL_W-1:0] valve_position_i,
  input wire logic [VAL_W-1:0] position_very_low_threshold_i,
  input wire logic [VAL_W-1:0] position_very_high_threshold_i,
  input wire logic [VAL_W-1:0] position_low_threshold_i,
  input wire logic [VAL_W-1:0] position_high_threshold_i,
  // Parameter write from the master
  input wire logic history_clear_parameter_we_i,
  input wire logic [diag_pkg::PARAM_W-1:0] history_clear_parameter_i,
  // Events that announce extension data in the main diagnosis word
  input wire logic extension_event_i,
  // Diagnosis bytes and extension-available flag
  output logic [7:0] live_system_faults_o,
  output logic [7:0] live_extra_system_faults_o,
  output logic [7:0] live_process_alarms_o,
  output logic [7:0] sticky_system_faults_o,
  output logic [7:0] sticky_extra_system_faults_o,
  output logic [7:0] sticky_process_alarms_o,
  output logic extension_available_o
);

  logic [7:0] sys_nxt;
  logic [7:0] extra_nxt;
  logic [7:0] proc_nxt;
  logic [7:0] sys_r;
  logic [7:0] extra_r;
  logic [7:0] proc_r;
  logic [CNT_W-1:0] dwell_r;
  logic deviation_hit;
  logic clear_hit;
  logic ext_r;

  // ------------------------------------------------------------
  // Clear command decode
  // ------------------------------------------------------------
  assign clear_hit = history_clear_parameter_we_i
    && (history_clear_parameter_i == diag_pkg::HISTORY_CLEAR_VALUE);

  // ------------------------------------------------------------
  // Deviation dwell timer
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      dwell_r <= '0;
    else if (control_deviation_i < deviation_threshold_i)
      dwell_r <= '0;
    else if (dwell_r < deviation_dwell_cycles_i)
      dwell_r <= dwell_r + CNT_W'(1);
  end

  assign deviation_hit = (control_deviation_i >= deviation_threshold_i)
    && (dwell_r >= deviation_dwell_cycles_i);

  // ------------------------------------------------------------
  // Live condition vectors
  // ------------------------------------------------------------
  always_comb
  begin
    sys_nxt = {option_board_fault_i, pot_fault_i, ip_loop_broken_i,
      actuator_out_of_range_i, converter_fault_i, rom_checksum_fault_i,
      eeprom_checksum_fault_i, ram_test_fault_i};
    extra_nxt = {binary_input_active_i, feedback_cal_fault_i, loop_cal_fault_i,
      1'b0, 1'b0, config_invalid_i, 1'b0, 1'b0};
    extra_nxt[diag_pkg::B2_CYCLE] = stroke_cycle_count_i >= stroke_cycle_limit_i;
    extra_nxt[diag_pkg::B2_TRAVEL] = travel_sum_i >= travel_sum_limit_i;
    extra_nxt[diag_pkg::B2_TEMP_LOW] = board_temp_i < board_temp_low_threshold_i;
    extra_nxt[diag_pkg::B2_TEMP_HIGH] = board_temp_i > board_temp_high_threshold_i;
    proc_nxt = {output_pressure_implausible_i, 1'b0, autostart_failed_i,
      5'h00};
    proc_nxt[diag_pkg::B3_SUPPLY] = supply_pressure_reading_i < supply_pressure_min_i;
    proc_nxt[diag_pkg::B3_DEVIATION] = deviation_hit;
    proc_nxt[diag_pkg::B3_VERY_LOW] = valve_position_i <= position_very_low_threshold_i;
    proc_nxt[diag_pkg::B3_VERY_HIGH] = valve_position_i >= position_very_high_threshold_i;
    proc_nxt[diag_pkg::B3_LOW] = valve_position_i <= position_low_threshold_i;
    proc_nxt[diag_pkg::B3_HIGH] = valve_position_i >= position_high_threshold_i;
  end

  // ------------------------------------------------------------
  // Live bytes follow conditions each cycle
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      sys_r <= 8'h00;
      extra_r <= 8'h00;
      proc_r <= 8'h00;
    end
    else
    begin
      sys_r <= sys_nxt;
      extra_r <= extra_nxt;
      proc_r <= proc_nxt;
    end
  end

  assign live_system_faults_o = sys_r;
  assign live_extra_system_faults_o = extra_r;
  assign live_process_alarms_o = proc_r;

  // ------------------------------------------------------------
  // History bytes
  // ------------------------------------------------------------
  sticky_if hist_sys ();
  sticky_if hist_extra ();
  sticky_if hist_proc ();

  assign hist_sys.live = sys_r;
  assign hist_sys.clear = clear_hit;
  assign hist_extra.live = extra_r;
  assign hist_extra.clear = clear_hit;
  assign hist_proc.live = proc_r;
  assign hist_proc.clear = clear_hit;

  sticky_byte u_sys (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port_s(hist_sys.keeper)
  );
  sticky_byte u_extra (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port_s(hist_extra.keeper)
  );
  sticky_byte u_proc (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port_s(hist_proc.keeper)
  );

  assign sticky_system_faults_o = hist_sys.hist;
  assign sticky_extra_system_faults_o = hist_extra.hist;
  assign sticky_process_alarms_o = hist_proc.hist;

  // ------------------------------------------------------------
  // Extension-available flag, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      ext_r <= 1'b0;
    else if (extension_event_i)
      ext_r <= 1'b1;
    else if (clear_hit)
      ext_r <= 1'b0;
  end

  assign extension_available_o = ext_r;
endmodule : positioner_extended_diagnosis

// ==== src/diag_pkg.sv ====
package diag_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_BYTES = 6;
  localparam int unsigned PARAM_W = 16;
  localparam logic [15:0] HISTORY_CLEAR_VALUE = 16'h8000;
  localparam int unsigned VAL_W = 16;
  localparam int unsigned CNT_W = 32;
  // Byte two bit positions
  localparam int unsigned B2_CYCLE = 4;
  localparam int unsigned B2_TRAVEL = 3;
  localparam int unsigned B2_TEMP_LOW = 1;
  localparam int unsigned B2_TEMP_HIGH = 0;
  // Byte three bit positions
  localparam int unsigned B3_SUPPLY = 6;
  localparam int unsigned B3_DEVIATION = 4;
  localparam int unsigned B3_VERY_LOW = 3;
  localparam int unsigned B3_VERY_HIGH = 2;
  localparam int unsigned B3_LOW = 1;
  localparam int unsigned B3_HIGH = 0;
endpackage : diag_pkg

// ==== src/sticky_if.sv ====
interface sticky_if;
  logic [7:0] live;
  logic clear;
  logic [7:0] hist;
  modport owner (output live, output clear, input hist);
  modport keeper (input live, input clear, output hist);
endinterface : sticky_if

// ==== src/sticky_byte.sv ====
module sticky_byte
(
  input wire logic clock_i,
  input wire logic resetn_i,
  sticky_if.keeper port_s
);
  logic [7:0] hist_r;

  // ------------------------------------------------------------
  // History latch, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      hist_r <= 8'h00;
    else if (port_s.clear)
      hist_r <= port_s.live;
    else
      hist_r <= hist_r | port_s.live;
  end

  assign port_s.hist = hist_r;
endmodule : sticky_byte

// ==== bench/diag_checker.sv ====
module diag_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ram_test_fault_i,
  input wire logic history_clear_parameter_we_i,
  input wire logic [15:0] history_clear_parameter_i,
  input wire logic extension_event_i,
  input wire logic [7:0] live_system_faults_o,
  input wire logic [7:0] sticky_system_faults_o,
  input wire logic extension_available_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic clr;
  assign clr = history_clear_parameter_we_i && history_clear_parameter_i == 16'h8000;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  live_follow_a: assert property ($past(resetn_i) |-> live_system_faults_o[0] == $past(ram_test_fault_i))
    else $error("live bit differs");
  live_drop_a: assert property ($past(resetn_i) && $fell(ram_test_fault_i) && !clr
    |=> !live_system_faults_o[0] && sticky_system_faults_o[0]) else $error("drop wrong");
  sticky_set_a: assert property (live_system_faults_o[0] |=> sticky_system_faults_o[0])
    else $error("history not set");
  sticky_hold_a: assert property (!clr |=> (sticky_system_faults_o & $past(sticky_system_faults_o))
    == $past(sticky_system_faults_o)) else $error("history lost");
  clear_load_a: assert property (clr |=> sticky_system_faults_o == $past(live_system_faults_o))
    else $error("clear wrong");
  ext_clear_a: assert property (clr && !extension_event_i |=> !extension_available_o)
    else $error("flag not cleared");
  ext_set_a: assert property (extension_event_i |=> extension_available_o)
    else $error("flag not set");
  ext_hold_a: assert property (!clr && !extension_event_i |=> $stable(extension_available_o))
    else $error("flag moved");
  cover property (clr);
  cover property (history_clear_parameter_we_i && !clr);
  cover property (extension_event_i);
endmodule : diag_checker

// ==== bench/bus_master.sv ====
module bus_master (
  input wire logic clock_i,
  output logic we_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    we_o = 1'b0;
    data_o = 16'h0;
  end
  task automatic write_param(input logic [15:0] val);
    @(negedge clock_i);
    we_o = 1'b1;
    data_o = val;
    @(negedge clock_i);
    we_o = 1'b0;
    data_o = ~val;
  endtask : write_param
endmodule : bus_master

// ==== bench/tb.sv ====
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("unexpected %0t %h %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [13:0] c;
  logic ev = 1'b0;
  logic ext, we;
  logic [15:0] pd;
  logic [31:0] w[5];
  logic [15:0] v[12];
  logic [7:0] o[6];
  logic [23:0] hist = 24'h0;
  int n_fail = 0, compares = 0, cyc = 0;
  always #10 clock_i = ~clock_i;
  bus_master i_bus_master (.clock_i(clock_i), .we_o(we), .data_o(pd));
  positioner_extended_diagnosis i_positioner_extended_diagnosis (.clock_i(clock_i), .resetn_i(resetn_i),
    .option_board_fault_i(c[7]), .pot_fault_i(c[6]), .ip_loop_broken_i(c[5]), .actuator_out_of_range_i(c[4]),
    .converter_fault_i(c[3]), .rom_checksum_fault_i(c[2]), .eeprom_checksum_fault_i(c[1]),
    .ram_test_fault_i(c[0]), .binary_input_active_i(c[8]), .feedback_cal_fault_i(c[9]),
    .loop_cal_fault_i(c[10]), .config_invalid_i(c[11]), .output_pressure_implausible_i(c[12]),
    .autostart_failed_i(c[13]), .stroke_cycle_count_i(w[0]), .stroke_cycle_limit_i(w[1]),
    .travel_sum_i(w[2]), .travel_sum_limit_i(w[3]), .board_temp_i(v[0]), .board_temp_low_threshold_i(v[1]),
    .board_temp_high_threshold_i(v[2]), .supply_pressure_reading_i(v[3]), .supply_pressure_min_i(v[4]),
    .control_deviation_i(v[5]), .deviation_threshold_i(v[6]), .deviation_dwell_cycles_i(w[4]),
    .valve_position_i(v[7]), .position_very_low_threshold_i(v[8]), .position_very_high_threshold_i(v[9]),
    .position_low_threshold_i(v[10]), .position_high_threshold_i(v[11]), .history_clear_parameter_we_i(we),
    .history_clear_parameter_i(pd), .extension_event_i(ev), .live_system_faults_o(o[0]),
    .live_extra_system_faults_o(o[1]), .live_process_alarms_o(o[2]), .sticky_system_faults_o(o[3]),
    .sticky_extra_system_faults_o(o[4]), .sticky_process_alarms_o(o[5]), .extension_available_o(ext));
  function logic [23:0] live_exp();
    live_exp[23:16] = c[7:0];
    live_exp[15:8] = {c[8], c[9], c[10], w[0] >= w[1], w[2] >= w[3], c[11], v[0] < v[1], v[0] > v[2]};
    live_exp[7:0] = {c[12], v[3] < v[4], c[13], v[5] >= v[6], v[7] <= v[8], v[7] >= v[9], v[7] <= v[10],
      v[7] >= v[11]};
  endfunction : live_exp
  task deflt;
    c = 14'h0;
    w = '{32'h0, 32'h64, 32'h0, 32'h64, 32'h0};
    v = '{16'h0a, 16'h05, 16'h14, 16'h0a, 16'h05, 16'h0, 16'h64, 16'h32, 16'h0a, 16'h5a, 16'h14, 16'h50};
  endtask : deflt
  task check(input string s);
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    hist = hist | live_exp();
    `CHK({o[0], o[1], o[2]}, live_exp())
    `CHK({o[3], o[4], o[5]}, hist)
    $display("test %s done", s);
  endtask : check
  task close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      close_out;
    end
  end
  initial
  begin
    deflt;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i) resetn_i = 1'b1;
    `CHK({o[0], o[1], o[2], o[3], o[4], o[5], ext}, 49'h0)
    for (int i = 0; i < 14; i++)
    begin
      c = 14'h1 << i;
      check("walk");
    end
    c = 14'h0;
    w[0] = 32'h64;
    v[0] = 16'h05;
    check("cycles");
    w[0] = 32'h0;
    w[2] = 32'h64;
    v[0] = 16'h04;
    check("travel");
    v[0] = 16'h15;
    v[3] = 16'h04;
    v[7] = 16'h0a;
    check("low");
    v[7] = 16'h5a;
    v[5] = 16'h64;
    check("high");
    ev = 1'b1;
    @(negedge clock_i) ev = 1'b0;
    `CHK(ext, 1'b1)
    i_bus_master.write_param(16'h8001);
    `CHK({o[3], o[4], o[5], ext}, {hist, 1'b1})
    i_bus_master.write_param(16'h8000);
    hist = live_exp();
    `CHK({o[3], o[4], o[5], ext}, {hist, 1'b0})
    $display("test clear done");
    deflt;
    i_bus_master.write_param(16'h8000);
    hist = live_exp();
    `CHK({o[3], o[4], o[5]}, hist)
    w[4] = 32'h3;
    v[5] = 16'h64;
    repeat (2) @(negedge clock_i);
    `CHK(o[2][diag_pkg::B3_DEVIATION], 1'b0)
    v[5] = 16'h0;
    check("short deviation");
    v[5] = 16'h64;
    repeat (3) @(negedge clock_i);
    `CHK(o[2][diag_pkg::B3_DEVIATION], 1'b0)
    check("long deviation");
    close_out;
  end
endmodule : tb
bind positioner_extended_diagnosis diag_checker i_diag_checker (.*);
